/* diag_results_responder.sv */
/*
  Holds the response byte FIFO and the target-side handler for the diagnostic results command.
  Assumes command bytes, the send-diagnostic record and the register port all run on clk;
  the bus-phase logic drains the data-in stream and raises status after cmdDone.
*/
// Decided for this implementation: the address map and strobed register access.
// Notes on behaviour
// - six-byte descriptor: opcode 1Ch, flag bit0 byte1, page, length MSB first, control.
// - flag clear selects the answer from the last accepted send-diagnostic command.
// - flag set selects the answer from the descriptor page code.
// - allocation length bounds bytes sent; zero means none.
// - data-in ends at the smaller of allocation length and available bytes.
// - prior send-diagnostic without page format gives the default data block.
// - only pages 00h and 40h exist and get their own layout.
// - default block bytes 0-1 hold additional length 0006h.
// - bytes 2-5 hold replaceable unit codes, most probable first.
// - all four replaceable unit codes are 00h, no information.
// - bytes 6-7 hold the error code, low byte the fault code.
// - fault code byte encodings come from firmware through the error code register.
// - nothing follows byte 7 of the default block.
// - prior page-format request for page 00h returns the supported pages page.
// - supported page: code 00h, reserved byte, list length n-3.
// - list from byte 4 holds 00h then 40h, ascending.
`timescale 1ns/10ps
`include "diag_results_defs.svh"

// ----------------------------------------
// shift FIFO, head always in a flip-flop
// ----------------------------------------
module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count;
  wire pop = outValid && outReady;
  wire push = inValid && inReady;
  wire [$clog2(DEPTH+1)-1:0] next_count = count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);

  assign outData = mem[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      // each slot takes the new word if it lands here, else on a pop its upper neighbour; the top slot keeps its word
      wire [$clog2(DEPTH+1)-1:0] landAt = pop ? count - 1'b1 : count;
      always_ff @(posedge clk) begin
        if (push && landAt == i)
          mem[i] <= inData;
        else if (pop && i < DEPTH - 1)
          mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
      outValid <= 1'b0;
      inReady <= 1'b1;
    end else begin
      count <= next_count;
      outValid <= next_count != 0;
      inReady <= next_count != DEPTH;
    end
  end
endmodule

// ----------------------------------------
// responder
// ----------------------------------------
module diag_results_responder
  import diag_results_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cdbValid,
  input wire logic [7:0] cdbData,
  input wire logic sdAccept,
  input wire logic [7:0] sdByte1,
  input wire logic [7:0] sdPageCode,
  output logic dataValid,
  input wire logic dataReady,
  output logic [7:0] dataByte,
  output logic cmdDone,
  output logic cmdCheck,
  output logic xlateReq,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);
  import diag_results_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  resp_state_t state;
  resp_src_t src;
  logic [7:0] cdb [6];
  logic [2:0] cdbIdx;
  logic pcvEnable;
  logic [15:0] errCode;
  logic sdSeen;
  logic page_format_flag;
  logic [7:0] sdPage;
  logic [15:0] sendLen;
  logic [15:0] pushCount;
  logic fifoInReady;

  // ----------------------------------------
  // decode of the held descriptor
  // ----------------------------------------
  wire opcodeOk = cdb[0] == `CDB_OPCODE;
  wire page_select_valid = cdb[1][`CDB_PSV_BIT] && pcvEnable;
  wire [7:0] reqPage = cdb[2];
  wire [15:0] allocLen = {cdb[3], cdb[4]};

  function automatic resp_src_t pageSrc(input logic [7:0] page);
    if (page == `PAGE_SUPPORTED)
      return SRC_SUPPORTED;
    if (page == `PAGE_XLATE)
      return SRC_XLATE;
    return SRC_ERROR;
  endfunction

  // no prior request or no page format: default block
  wire resp_src_t sdSrc = (!sdSeen || !page_format_flag) ? SRC_DEFAULT : pageSrc(sdPage);
  wire resp_src_t pickSrc = !opcodeOk ? SRC_ERROR :
                            page_select_valid ? pageSrc(reqPage) : sdSrc;
  wire [15:0] availLen = pickSrc == SRC_DEFAULT ? `DEFAULT_LEN :
                         pickSrc == SRC_SUPPORTED ? `SUP_LEN : 16'h0000;
  wire [15:0] next_sendLen = allocLen < availLen ? allocLen : availLen;

  function automatic logic [7:0] respByte(input resp_src_t s, input logic [15:0] idx, input logic [15:0] ec);
    logic [7:0] b;
    b = 8'h00;
    if (s == SRC_DEFAULT) begin
      unique case (idx)
        16'h0000: b = 8'(`DEFAULT_ADDL_LEN >> 8);
        16'h0001: b = 8'(`DEFAULT_ADDL_LEN & 16'h00ff);
        16'h0006: b = ec[15:8];
        16'h0007: b = ec[7:0];
        default: b = `UNIT_CODE_NONE;
      endcase
    end else begin
      unique case (idx)
        16'h0000: b = `PAGE_SUPPORTED;
        16'h0002: b = 8'(`SUP_LIST_LEN >> 8);
        16'h0003: b = 8'(`SUP_LIST_LEN & 16'h00ff);
        16'h0004: b = `PAGE_SUPPORTED;
        16'h0005: b = `PAGE_XLATE;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  wire pushing = state == ST_SEND && pushCount != sendLen;
  wire [7:0] pushByte = respByte(src, pushCount, errCode);
  wire fifoPush = pushing && fifoInReady;

  // ----------------------------------------
  // fifo toward the data-in phase
  // ----------------------------------------
  resp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(pushing),
    .inReady(fifoInReady),
    .inData(pushByte),
    .outValid(dataValid),
    .outReady(dataReady),
    .outData(dataByte)
  );

  // ----------------------------------------
  // command sequence
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_COLLECT;
      cdbIdx <= 3'h0;
      src <= SRC_DEFAULT;
      sendLen <= 16'h0000;
      pushCount <= 16'h0000;
      cmdDone <= 1'b0;
      cmdCheck <= 1'b0;
      xlateReq <= 1'b0;
    end else begin
      cmdDone <= 1'b0;
      xlateReq <= 1'b0;
      unique case (state)
        ST_COLLECT: begin
          if (cdbValid) begin
            cdbIdx <= cdbIdx + 3'h1;
            if (cdbIdx == `CDB_LEN - 3'h1) begin
              cdbIdx <= 3'h0;
              state <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE: begin
          src <= pickSrc;
          sendLen <= next_sendLen;
          pushCount <= 16'h0000;
          cmdCheck <= pickSrc == SRC_ERROR;
          // translate page layout lives elsewhere; hand it over
          xlateReq <= pickSrc == SRC_XLATE;
          state <= ST_SEND;
        end
        ST_SEND: begin
          if (fifoPush)
            pushCount <= pushCount + 16'h0001;
          if (!pushing)
            state <= ST_DRAIN;
        end
        ST_DRAIN: begin
          // phase ends only once the last byte has left the fifo
          if (!dataValid)
            state <= ST_FINISH;
        end
        ST_FINISH: begin
          cmdDone <= 1'b1;
          state <= ST_COLLECT;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state == ST_COLLECT && cdbValid)
      cdb[cdbIdx] <= cdbData;
  end

  // ----------------------------------------
  // send-diagnostic record
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdSeen <= 1'b0;
      page_format_flag <= 1'b0;
      sdPage <= 8'h00;
    end else if (sdAccept) begin
      sdSeen <= 1'b1;
      page_format_flag <= sdByte1[`SEND_DIAG_PF_BIT];
      sdPage <= sdPageCode;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  wire selCtrl = regAddr == `REG_CTRL_OFS;
  wire selErr = regAddr == `REG_ERRCODE_OFS;
  wire selStat = regAddr == `REG_STATUS_OFS;
  wire selSd = regAddr == `REG_SDREC_OFS;
  wire busy = state != ST_COLLECT;
  wire [31:0] next_regRdata = selCtrl ? {31'h0, pcvEnable} :
                              selErr ? {16'h0, errCode} :
                              selStat ? {pushCount, 12'h0, cmdCheck, src, busy} :
                              selSd ? {22'h0, sdSeen, page_format_flag, sdPage} : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcvEnable <= `CTRL_RESET;
      errCode <= `ERRCODE_RESET;
      regRdata <= 32'h0;
    end else begin
      if (regWr && selCtrl)
        pcvEnable <= regWdata[`CTRL_PCV_EN_BIT];
      if (regWr && selErr)
        errCode <= regWdata[15:0];
      // unmapped or idle reads return zero
      regRdata <= regRd ? next_regRdata : 32'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // the byte checks watch bytes as they enter the fifo; the far side may take them much later
  a_push_bound: assert property (@(posedge clk) disable iff (sys_rst) pushCount <= sendLen)
    else $error("pushed past length");
  a_len_choice: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DECIDE |=> sendLen == $past(next_sendLen) && sendLen <= $past(allocLen))
    else $error("length not min of allocation and data");
  a_zero_alloc: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DECIDE && allocLen == 16'h0000 |=> !pushing [*2])
    else $error("data with zero allocation");
  a_default_hdr: assert property (@(posedge clk) disable iff (sys_rst)
    fifoPush && src == SRC_DEFAULT && pushCount == 16'h0001 |-> pushByte == 8'h06)
    else $error("bad additional length");
  a_unit_codes: assert property (@(posedge clk) disable iff (sys_rst)
    fifoPush && src == SRC_DEFAULT && pushCount >= 16'h0002 && pushCount <= 16'h0005 |-> pushByte == 8'h00)
    else $error("unit code not zero");
  a_default_size: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_SEND && src == SRC_DEFAULT |-> sendLen <= 16'h0008)
    else $error("default block too long");
  a_sup_list: assert property (@(posedge clk) disable iff (sys_rst)
    fifoPush && src == SRC_SUPPORTED && pushCount == 16'h0005 |-> pushByte == 8'h40)
    else $error("supported list wrong");
  a_bad_page: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DECIDE && opcodeOk && page_select_valid && reqPage != 8'h00 && reqPage != 8'h40
    |=> cmdCheck && sendLen == 16'h0000)
    else $error("unsupported page not refused");
  a_sd_select: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DECIDE && opcodeOk && !page_select_valid && !page_format_flag |=> src == SRC_DEFAULT)
    else $error("default block not chosen");
  a_done_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    cmdDone |-> !dataValid && $past(state == ST_FINISH) ##1 !cmdDone)
    else $error("done before drain");
  a_sup_len: assert property (@(posedge clk) disable iff (sys_rst)
    fifoPush && src == SRC_SUPPORTED && pushCount == 16'h0003 |-> pushByte == 8'h02)
    else $error("supported list length wrong");
  a_sup_codes: assert property (@(posedge clk) disable iff (sys_rst)
    fifoPush && src == SRC_SUPPORTED && (pushCount == 16'h0000 || pushCount == 16'h0004) |-> pushByte == 8'h00)
    else $error("supported page code wrong");
  a_xlate_only: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DECIDE && pickSrc == SRC_XLATE |=> xlateReq && !cmdCheck && sendLen == 16'h0000)
    else $error("translate page not handed over");
  a_bad_opcode: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_DECIDE && !opcodeOk |=> cmdCheck && src == SRC_ERROR)
    else $error("wrong opcode not refused");
  a_pf_record: assert property (@(posedge clk) disable iff (sys_rst)
    sdAccept |=> sdSeen && page_format_flag == $past(sdByte1[`SEND_DIAG_PF_BIT]))
    else $error("page format not recorded");
  a_check_hold: assert property (@(posedge clk) disable iff (sys_rst)
    state != ST_DECIDE |=> $stable(cmdCheck))
    else $error("check status moved outside decide");
endmodule

/* diag_results_defs.svh */
/*
  Holds the offsets, field positions, reset values and fixed byte values of the diagnostic results responder.
  Assumes it is included by its bare name from the design file and the bench.
*/
`ifndef DIAG_RESULTS_DEFS_SVH
`define DIAG_RESULTS_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL_OFS 8'h00
`define REG_ERRCODE_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_SDREC_OFS 8'h0c

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_PCV_EN_BIT 0
`define CTRL_RESET 1'b1
`define ERRCODE_RESET 16'h0000

// ----------------------------------------
// command descriptor
// ----------------------------------------
`define CDB_LEN 3'h6
`define CDB_OPCODE 8'h1c
`define CDB_PSV_BIT 0

// ----------------------------------------
// response data
// ----------------------------------------
`define PAGE_SUPPORTED 8'h00
`define PAGE_XLATE 8'h40
`define DEFAULT_ADDL_LEN 16'h0006
`define DEFAULT_LEN 16'h0008
`define SUP_LIST_LEN 16'h0002
`define SUP_LEN 16'h0006
`define UNIT_CODE_NONE 8'h00
`define SEND_DIAG_PF_BIT 4

`endif

/* diag_results_pkg.sv */
/*
  Holds the types shared by the diagnostic results responder.
  Assumes the defs header is compiled alongside.
*/
package diag_results_pkg;
  typedef enum {ST_COLLECT, ST_DECIDE, ST_SEND, ST_DRAIN, ST_FINISH} resp_state_t;
  typedef enum logic [1:0] {SRC_DEFAULT, SRC_SUPPORTED, SRC_XLATE, SRC_ERROR} resp_src_t;
endpackage

/* initiator_model.sv */
/*
  Holds a behavioural initiator that takes data-in bytes from the responder.
  Assumes one clock and a synchronous, active-high reset shared with the responder.
*/
`timescale 1ns/10ps
module initiator_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic dataValid,
  input wire logic [7:0] dataByte,
  output logic dataReady
);
  logic [7:0] got [0:255];
  int nGot;
  logic [1:0] phase;
  // slow mode takes one cycle in four, so the fifo fills and the responder must wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= 2'h0;
      dataReady <= 1'b0;
      nGot <= 0;
    end else begin
      phase <= phase + 2'h1;
      dataReady <= !slow || (phase == 2'h3);
      if (dataValid && dataReady) begin
        got[nGot[7:0]] <= dataByte;
        nGot <= nGot + 1;
      end
    end
  end
endmodule

/* tb_diag_results_responder.sv */
/*
  Holds the self-checking bench of the diagnostic results responder.
  Assumes the defs header, the package, the design and the initiator model are compiled first.
*/
`timescale 1ns/10ps
`include "diag_results_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin $display("[ERR] %s exp %0h got %0h", nm, e, g); miscompares++; end end
module tb_diag_results_responder;
  typedef struct {logic pf; logic [7:0] sdPg; logic flag; logic [7:0] pg; logic [15:0] alloc;
    logic slow; logic [15:0] err; int src;} row_t;
  logic clk, sys_rst, cdbValid, sdAccept, dataValid, dataReady, cmdDone, cmdCheck, xlateReq, regWr, regRd, slow;
  logic [7:0] cdbData, sdByte1, sdPageCode, dataByte, regAddr;
  logic [31:0] regWdata, regRdata, rd;
  int miscompares, n_compared, cycles, nXl, base, n;
  logic chk;
  row_t rows [9];
  diag_results_responder u_diag_results_responder (.clk(clk), .sys_rst(sys_rst), .cdbValid(cdbValid),
    .cdbData(cdbData), .sdAccept(sdAccept), .sdByte1(sdByte1), .sdPageCode(sdPageCode), .dataValid(dataValid),
    .dataReady(dataReady), .dataByte(dataByte), .cmdDone(cmdDone), .cmdCheck(cmdCheck), .xlateReq(xlateReq),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  initiator_model u_initiator_model (.clk(clk), .sys_rst(sys_rst), .slow(slow), .dataValid(dataValid),
    .dataByte(dataByte), .dataReady(dataReady));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (xlateReq === 1'b1) nXl++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic regW(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regR(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic sendDiag(input logic pf, input logic [7:0] pg);
    @(posedge clk);
    sdAccept <= 1'b1;
    sdByte1 <= {3'h0, pf, 4'h0};
    sdPageCode <= pg;
    @(posedge clk);
    sdAccept <= 1'b0;
  endtask
  // six bytes back to back, then wait for completion
  task automatic cmd(input logic [7:0] op, input logic flag, input logic [7:0] pg, input logic [15:0] al);
    logic [7:0] b [6];
    b = '{op, {7'h0, flag}, pg, al[15:8], al[7:0], 8'h00};
    base = u_initiator_model.nGot;
    nXl = 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      cdbValid <= 1'b1;
      cdbData <= b[i];
    end
    @(posedge clk);
    cdbValid <= 1'b0;
    for (int i = 0; i < 200 && cmdDone !== 1'b1; i++) @(posedge clk);
    `CHK("done", 1'h1, cmdDone)
    chk = cmdCheck;
    n = u_initiator_model.nGot - base;
  endtask
  function automatic logic [7:0] expByte(int src, int i, logic [15:0] err);
    logic [7:0] dflt [8];
    logic [7:0] sup [6];
    dflt = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, err[15:8], err[7:0]};
    sup = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h40};
    return (src == 0) ? dflt[i] : sup[i];
  endfunction
  initial begin
    {sys_rst, cdbValid, sdAccept, regWr, regRd, slow} = 6'h20;
    {cdbData, sdByte1, sdPageCode, regAddr, regWdata} = '0;
    rows = '{
      '{1'b0, 8'h00, 1'b0, 8'h00, 16'h00ff, 1'b0, 16'h0081, 0},
      '{1'b0, 8'h00, 1'b0, 8'h00, 16'h0005, 1'b1, 16'h0260, 0},
      '{1'b0, 8'h00, 1'b0, 8'h00, 16'h0000, 1'b0, 16'h00c1, 0},
      '{1'b1, 8'h00, 1'b0, 8'h00, 16'h0100, 1'b1, 16'h0001, 1},
      '{1'b1, 8'h00, 1'b0, 8'h00, 16'h0003, 1'b0, 16'h0018, 1},
      '{1'b0, 8'h00, 1'b1, 8'h00, 16'h0006, 1'b0, 16'h0004, 1},
      '{1'b1, 8'h00, 1'b1, 8'h40, 16'h0010, 1'b0, 16'h0080, 2},
      '{1'b1, 8'h40, 1'b0, 8'h00, 16'h0010, 1'b0, 16'h0008, 2},
      '{1'b0, 8'h00, 1'b1, 8'h41, 16'h0010, 1'b0, 16'h0002, 3}};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    regR(`REG_CTRL_OFS);
    `CHK("ctrl", 32'h1, rd)
    regR(`REG_ERRCODE_OFS);
    `CHK("errcode", 32'h0, rd)
    regR(8'h20);
    `CHK("unmapped", 32'h0, rd)
    foreach (rows[r]) begin
      slow <= rows[r].slow;
      regW(`REG_ERRCODE_OFS, {16'h0, rows[r].err});
      sendDiag(rows[r].pf, rows[r].sdPg);
      cmd(`CDB_OPCODE, rows[r].flag, rows[r].pg, rows[r].alloc);
      `CHK("count", (rows[r].src == 0) ? ((rows[r].alloc < 8) ? rows[r].alloc : 8) :
        (rows[r].src == 1) ? ((rows[r].alloc < 6) ? rows[r].alloc : 6) : 0, n)
      for (int i = 0; i < n && i < 8; i++)
        `CHK("byte", expByte(rows[r].src, i, rows[r].err), u_initiator_model.got[base + i])
      `CHK("check", (rows[r].src == 3), chk)
      `CHK("xlate", (rows[r].src == 2), nXl)
    end
    regR(`REG_SDREC_OFS);
    `CHK("sdrec", 32'h200, rd)
    cmd(8'h12, 1'b0, 8'h00, 16'h0010);
    `CHK("bad op", 1, chk)
    `CHK("bad op n", 0, n)
    regW(`REG_CTRL_OFS, 32'h0);
    cmd(`CDB_OPCODE, 1'b1, 8'h41, 16'h0008);
    `CHK("flag off", 0, chk)
    `CHK("flag off n", 8, n)
    `CHK("last", 8'h02, u_initiator_model.got[base + 7])
    regR(`REG_STATUS_OFS);
    `CHK("status", 32'h0008_0000, rd)
    sendDiag(1'b1, 8'h41);
    cmd(`CDB_OPCODE, 1'b0, 8'h00, 16'h0008);
    `CHK("sd bad page", 1'h1, chk)
    `CHK("sd bad page n", 32'h0, n)
    // reset in mid-run must forget the control write, the record and the error code
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    regR(`REG_CTRL_OFS);
    `CHK("ctrl again", 32'h1, rd)
    regR(`REG_SDREC_OFS);
    `CHK("sdrec again", 32'h0, rd)
    cmd(`CDB_OPCODE, 1'b0, 8'h00, 16'h0008);
    `CHK("fresh check", 1'h0, chk)
    `CHK("fresh n", 32'h8, n)
    `CHK("fresh len", 8'h06, u_initiator_model.got[base + 1])
    `CHK("fresh err", 8'h00, u_initiator_model.got[base + 7])
    results();
  end
endmodule
